// ===== logic/asb_defines.svh
// Purpose: constants for the accumulator, shift and bit decode block
// Assumes: flag byte laid out sign, zero, -, half, -, parity/overflow, subtract, carry
// Notes: opcode values, flag positions and reset values only
`ifndef ASB_DEFINES_SVH
`define ASB_DEFINES_SVH
`define ASB_OP_DECADJ 8'h27
`define ASB_OP_INVACC 8'h2f
`define ASB_OP_FLIPC 8'h3f
`define ASB_OP_FORCEC 8'h37
`define ASB_ED_NEG 8'h44
`define ASB_ED_RRD 8'h67
`define ASB_ED_RLD 8'h6f
`define ASB_PFX_CB 8'hcb
`define ASB_PFX_ED 8'hed
`define ASB_PFX_DD 8'hdd
`define ASB_PFX_FD 8'hfd
`define ASB_FL_S 7
`define ASB_FL_Z 6
`define ASB_FL_H 4
`define ASB_FL_PV 2
`define ASB_FL_N 1
`define ASB_FL_C 0
`define ASB_RST_ACC 8'hff
`define ASB_RST_FLAGS 8'hff
`define ASB_RST_PAIR 16'hffff
`endif

// ===== logic/asb_pkg.sv
// Purpose: types for the accumulator, shift and bit decode block
// Assumes: nothing beyond the defines header
// Notes: decode state enumeration
package asb_pkg;
    typedef enum logic [2:0] {
        ASB_IDLE = 3'b000,
        ASB_OP2 = 3'b001,
        ASB_EDOP = 3'b010,
        ASB_CBOP = 3'b011,
        ASB_XCB = 3'b100,
        ASB_XDISP = 3'b101,
        ASB_XOP = 3'b110,
        ASB_MWAIT = 3'b111
    } asb_state_e;
endpackage : asb_pkg

// ===== logic/asb_decode.sv
// Purpose: decode and execute accumulator, 16-bit pair, rotate/shift and bit operations
// Assumes: one opcode byte offered per op_valid; memory reads answer next cycle or later
// Notes: register file kept here; other opcodes are dropped back to idle
// Operation
// - 27 adjusts the accumulator to decimal, 2f inverts it, ed 44 negates it.
// - 3f flips the carry and 37 forces the carry.
// - 09/19/29/39 add a pair into the pointer pair, dd/fd on this or the previous instruction redirect to an index register.
// - ed 4a/5a/6a/7a add a pair plus carry into the pointer pair and set flags.
// - ed 42/52/62/72 subtract a pair and borrow from the pointer pair and set flags.
// - rotates and shifts act on the accumulator, any general register or memory.
// - arithmetic shift right keeps the sign and logical shift right fills with zero.
// - ed 6f and ed 67 rotate one accumulator digit with the two digits of memory.
// - one instruction sets, clears or tests any bit of a register or memory byte.
// - all 240 bit operation variants over bit, operation and address form decode.
// - register addressing picks the accumulator or any general register.
// - memory bit operations use the pointer pair or an index plus displacement.
// - a bit test sets zero when the bit is zero and leaves the operand alone.
// - negate replaces the accumulator with its two's complement.
// - subtract flag marks the last subtraction and steers the decimal adjust.
`timescale 1ns/1ps
`include "asb_defines.svh"
module asb_decode (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // opcode byte stream
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    output logic op_ready,
    // memory operand port
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_addr_ff,
    output logic [7:0] mem_wdata_ff,
    input wire logic mem_rvalid,
    input wire logic [7:0] mem_rdata,
    // visible register state
    output logic [7:0] acc_ff,
    output logic [7:0] flags_ff,
    output logic [15:0] byte_count_pair_ff,
    output logic [15:0] target_pair_ff,
    output logic [15:0] memory_pointer_pair_ff,
    output logic [15:0] stack_pointer_ff,
    output logic [15:0] index_reg_x_ff,
    output logic [15:0] index_reg_y_ff,
    output logic done_ff
);
    import asb_pkg::*;

    asb_state_e state_ff;
    logic [1:0] pfx_ff; // 0 none, 1 x, 2 y
    logic [7:0] disp_ff;
    logic [7:0] opc_ff;
    logic [7:0] gp_ff [0:7]; // b c d e h l - a slots, 6 and 7 unused
    logic wr_pend_ff;

    // even parity flag helper
    function automatic logic par8(input logic [7:0] v);
        par8 = ~^v;
    endfunction : par8

    // rotate/shift unit: {carry_out, result}
    function automatic logic [8:0] rot(input logic [2:0] k, input logic [7:0] v,
                                       input logic c);
        case (k)
            3'd0: rot = {v[7], v[6:0], v[7]};
            3'd1: rot = {v[0], v[0], v[7:1]};
            3'd2: rot = {v[7], v[6:0], c}; // rotate_with_flag_left
            3'd3: rot = {v[0], c, v[7:1]}; // rotate_with_flag_right
            3'd4: rot = {v[7], v[6:0], 1'b0}; // arith_shift_left
            3'd5: rot = {v[0], v[7], v[7:1]}; // arith_shift_right keeps sign
            3'd6: rot = {v[7], v[6:0], 1'b1};
            default: rot = {v[0], 1'b0, v[7:1]}; // logic_shift_right zero fill
        endcase
    endfunction : rot

    // cb-group result: {flags, value, writes_back}
    function automatic logic [16:0] cbop(input logic [7:0] o, input logic [7:0] v,
                                         input logic [7:0] f);
        logic [8:0] r;
        logic [7:0] nf;
        logic [7:0] bm;
        r = rot(o[5:3], v, f[`ASB_FL_C]);
        nf = f;
        bm = 8'h01 << o[5:3];
        case (o[7:6])
            2'b00:
            begin
                nf = {r[7], (r[7:0] == 8'h00), 1'b0, 1'b0, 1'b0, par8(r[7:0]), 1'b0, r[8]};
                cbop = {nf, r[7:0], 1'b1};
            end
            2'b01:
            begin
                nf[`ASB_FL_Z] = ~|(v & bm);
                nf[`ASB_FL_PV] = ~|(v & bm);
                nf[`ASB_FL_H] = 1'b1;
                nf[`ASB_FL_N] = 1'b0;
                cbop = {nf, v, 1'b0};
            end
            2'b10: cbop = {f, v & ~bm, 1'b1};
            default: cbop = {f, v | bm, 1'b1};
        endcase
    endfunction : cbop

    // pair select by opcode bits 5:4, pointer slot follows the prefix only for the 09 group adds
    function automatic logic [15:0] pairsel(input logic [1:0] s, input logic [15:0] bc,
                                            input logic [15:0] de, input logic [15:0] hl,
                                            input logic [15:0] sp);
        case (s)
            2'd0: pairsel = bc;
            2'd1: pairsel = de;
            2'd2: pairsel = hl;
            default: pairsel = sp;
        endcase
    endfunction : pairsel

    logic [15:0] ptr_sel;
    logic [15:0] idx_addr;
    logic [7:0] reg_v;
    assign ptr_sel = (pfx_ff == 2'd1) ? index_reg_x_ff :
                     (pfx_ff == 2'd2) ? index_reg_y_ff : memory_pointer_pair_ff;
    assign idx_addr = ptr_sel + {{8{disp_ff[7]}}, disp_ff};
    assign reg_v = (op_byte[2:0] == 3'd7) ? acc_ff : gp_ff[op_byte[2:0]];
    // stall byte intake while a memory operand is outstanding
    assign op_ready = (state_ff != ASB_MWAIT) && !wr_pend_ff;
    assign mem_wr = wr_pend_ff;
    assign byte_count_pair_ff = {gp_ff[0], gp_ff[1]};
    assign target_pair_ff = {gp_ff[2], gp_ff[3]};
    assign memory_pointer_pair_ff = {gp_ff[4], gp_ff[5]};

    logic take;
    assign take = op_valid && op_ready;

    // one block owns architectural state so each register has one driver
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ASB_IDLE;
            pfx_ff <= 2'd0;
            disp_ff <= 8'h00;
            opc_ff <= 8'h00;
            acc_ff <= `ASB_RST_ACC;
            flags_ff <= `ASB_RST_FLAGS;
            for (int i = 0; i < 8; i++) gp_ff[i] <= 8'hff;
            stack_pointer_ff <= `ASB_RST_PAIR;
            index_reg_x_ff <= `ASB_RST_PAIR;
            index_reg_y_ff <= `ASB_RST_PAIR;
            mem_rd <= 1'b0;
            wr_pend_ff <= 1'b0;
            mem_addr_ff <= 16'h0000;
            mem_wdata_ff <= 8'h00;
            done_ff <= 1'b0;
        end
        else
        begin
            logic [16:0] cr;
            logic [16:0] sum;
            logic [15:0] src;
            logic [7:0] a;
            logic [7:0] adj;
            logic [8:0] rr;
            cr = 17'h00000;
            sum = 17'h00000;
            src = 16'h0000;
            a = acc_ff;
            adj = 8'h00;
            rr = 9'h000;
            done_ff <= 1'b0;
            mem_rd <= 1'b0;
            wr_pend_ff <= 1'b0;
            case (state_ff)
                ASB_IDLE, ASB_OP2:
                if (take)
                begin
                    state_ff <= ASB_IDLE;
                    if (state_ff == ASB_IDLE) pfx_ff <= 2'd0;
                    if (op_byte == `ASB_PFX_DD || op_byte == `ASB_PFX_FD)
                    begin
                        pfx_ff <= (op_byte == `ASB_PFX_DD) ? 2'd1 : 2'd2;
                        state_ff <= ASB_OP2;
                    end
                    else if (op_byte == `ASB_PFX_ED)
                        state_ff <= ASB_EDOP;
                    else if (op_byte == `ASB_PFX_CB)
                        state_ff <= (pfx_ff != 2'd0 && state_ff == ASB_OP2) ?
                                    ASB_XDISP : ASB_CBOP;
                    else if (op_byte == `ASB_OP_DECADJ)
                    begin
                        // correction direction follows the subtract flag
                        if (flags_ff[`ASB_FL_H] || a[3:0] > 4'h9) adj[3:0] = 4'h6;
                        if (flags_ff[`ASB_FL_C] || a > 8'h99) adj[7:4] = 4'h6;
                        a = flags_ff[`ASB_FL_N] ? acc_ff - adj : acc_ff + adj;
                        acc_ff <= a;
                        flags_ff <= {a[7], (a == 8'h00), 1'b0,
                                     flags_ff[`ASB_FL_N] ? (flags_ff[`ASB_FL_H] &&
                                     acc_ff[3:0] < 4'h6) : (acc_ff[3:0] > 4'h9),
                                     1'b0, par8(a), flags_ff[`ASB_FL_N],
                                     flags_ff[`ASB_FL_C] | (acc_ff > 8'h99)};
                        done_ff <= 1'b1;
                    end
                    else if (op_byte == `ASB_OP_INVACC)
                    begin
                        acc_ff <= ~acc_ff;
                        flags_ff[`ASB_FL_H] <= 1'b1;
                        flags_ff[`ASB_FL_N] <= 1'b1;
                        done_ff <= 1'b1;
                    end
                    else if (op_byte == `ASB_OP_FLIPC)
                    begin
                        flags_ff[`ASB_FL_H] <= flags_ff[`ASB_FL_C];
                        flags_ff[`ASB_FL_C] <= ~flags_ff[`ASB_FL_C];
                        flags_ff[`ASB_FL_N] <= 1'b0;
                        done_ff <= 1'b1;
                    end
                    else if (op_byte == `ASB_OP_FORCEC)
                    begin
                        flags_ff[`ASB_FL_C] <= 1'b1;
                        flags_ff[`ASB_FL_H] <= 1'b0;
                        flags_ff[`ASB_FL_N] <= 1'b0;
                        done_ff <= 1'b1;
                    end
                    else if (op_byte[7:6] == 2'b00 && op_byte[3:0] == 4'h9)
                    begin
                        // pointer slot reads the destination itself under a prefix
                        src = (op_byte[5:4] == 2'd2) ? ptr_sel :
                              pairsel(op_byte[5:4], byte_count_pair_ff, target_pair_ff,
                                      memory_pointer_pair_ff, stack_pointer_ff);
                        sum = {1'b0, ptr_sel} + {1'b0, src};
                        if (pfx_ff == 2'd1) index_reg_x_ff <= sum[15:0];
                        else if (pfx_ff == 2'd2) index_reg_y_ff <= sum[15:0];
                        else {gp_ff[4], gp_ff[5]} <= sum[15:0];
                        flags_ff[`ASB_FL_C] <= sum[16];
                        flags_ff[`ASB_FL_N] <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end
                ASB_EDOP:
                if (take)
                begin
                    state_ff <= ASB_IDLE;
                    src = pairsel(op_byte[5:4], byte_count_pair_ff, target_pair_ff,
                                  memory_pointer_pair_ff, stack_pointer_ff);
                    if (op_byte == `ASB_ED_NEG)
                    begin
                        a = 8'h00 - acc_ff;
                        acc_ff <= a;
                        flags_ff <= {a[7], (a == 8'h00), 1'b0, (acc_ff[3:0] != 4'h0), 1'b0,
                                     (acc_ff == 8'h80), 1'b1, (acc_ff != 8'h00)};
                        done_ff <= 1'b1;
                    end
                    else if (op_byte == `ASB_ED_RRD || op_byte == `ASB_ED_RLD)
                    begin
                        opc_ff <= op_byte;
                        mem_addr_ff <= memory_pointer_pair_ff;
                        mem_rd <= 1'b1;
                        state_ff <= ASB_MWAIT;
                    end
                    else if (op_byte[7:6] == 2'b01 && op_byte[2:0] == 3'd2)
                    begin
                        // op bit 3 picks add (4a) or subtract (42)
                        cr = op_byte[3] ?
                             {1'b0, memory_pointer_pair_ff} + {1'b0, src} +
                             {16'h0000, flags_ff[`ASB_FL_C]} :
                             {1'b0, memory_pointer_pair_ff} - {1'b0, src} -
                             {16'h0000, flags_ff[`ASB_FL_C]};
                        {gp_ff[4], gp_ff[5]} <= cr[15:0];
                        flags_ff <= {cr[15], (cr[15:0] == 16'h0000), 1'b0,
                                     cr[12] ^ memory_pointer_pair_ff[12] ^ src[12], 1'b0,
                                     op_byte[3] ?
                                     (memory_pointer_pair_ff[15] == src[15] &&
                                      cr[15] != src[15]) :
                                     (memory_pointer_pair_ff[15] != src[15] &&
                                      cr[15] == src[15]),
                                     ~op_byte[3], cr[16]};
                        done_ff <= 1'b1;
                    end
                end
                ASB_CBOP:
                if (take)
                begin
                    state_ff <= ASB_IDLE;
                    if (op_byte[2:0] == 3'd6)
                    begin
                        opc_ff <= op_byte;
                        mem_addr_ff <= memory_pointer_pair_ff;
                        mem_rd <= 1'b1;
                        state_ff <= ASB_MWAIT;
                    end
                    else
                    begin
                        cr = cbop(op_byte, reg_v, flags_ff);
                        flags_ff <= cr[16:9];
                        if (cr[0] && op_byte[2:0] == 3'd7) acc_ff <= cr[8:1];
                        else if (cr[0]) gp_ff[op_byte[2:0]] <= cr[8:1];
                        done_ff <= 1'b1;
                    end
                end
                ASB_XDISP:
                if (take)
                begin
                    disp_ff <= op_byte;
                    state_ff <= ASB_XOP;
                end
                ASB_XOP:
                if (take)
                begin
                    opc_ff <= op_byte;
                    mem_addr_ff <= idx_addr;
                    mem_rd <= 1'b1;
                    state_ff <= ASB_MWAIT;
                end
                ASB_MWAIT:
                if (mem_rvalid)
                begin
                    state_ff <= ASB_IDLE;
                    done_ff <= 1'b1;
                    if (opc_ff == `ASB_ED_RLD && pfx_ff == 2'd0 && !opc_ff[7])
                    begin
                        // memory gets low digit of mem and acc digit
                        mem_wdata_ff <= {mem_rdata[3:0], acc_ff[3:0]};
                        a = {acc_ff[7:4], mem_rdata[7:4]};
                        acc_ff <= a;
                        wr_pend_ff <= 1'b1;
                        flags_ff <= {a[7], (a == 8'h00), 1'b0, 1'b0, 1'b0, par8(a),
                                     1'b0, flags_ff[`ASB_FL_C]};
                    end
                    else if (opc_ff == `ASB_ED_RRD && pfx_ff == 2'd0)
                    begin
                        mem_wdata_ff <= {acc_ff[3:0], mem_rdata[7:4]};
                        a = {acc_ff[7:4], mem_rdata[3:0]};
                        acc_ff <= a;
                        wr_pend_ff <= 1'b1;
                        flags_ff <= {a[7], (a == 8'h00), 1'b0, 1'b0, 1'b0, par8(a),
                                     1'b0, flags_ff[`ASB_FL_C]};
                    end
                    else
                    begin
                        cr = cbop(opc_ff, mem_rdata, flags_ff);
                        flags_ff <= cr[16:9];
                        mem_wdata_ff <= cr[8:1];
                        wr_pend_ff <= cr[0]; // test leaves memory untouched
                    end
                end
                default: state_ff <= ASB_IDLE;
            endcase
        end
    end
endmodule : asb_decode

// ===== verification/asb_decode_chk.sv
// Purpose: port level checks of the decode block
// Assumes: only top module ports are visible
// Notes: two byte history tells plain opcodes from prefixed ones
`timescale 1ns/1ps
`include "asb_defines.svh"
module asb_decode_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // byte stream
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic op_ready,
    // memory port
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr_ff,
    input wire logic mem_rvalid,
    // state
    input wire logic [7:0] acc_ff,
    input wire logic [7:0] flags_ff,
    input wire logic done_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] b1_ff;
    logic [7:0] b2_ff;
    logic take;
    logic fresh;
    // a displacement equal to an opcode must not trigger a check
    assign take = op_valid && op_ready;
    assign fresh = !(b1_ff inside {8'hcb, 8'hed, 8'hdd, 8'hfd}) && b2_ff != 8'hcb;
    // last two bytes taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            b1_ff <= 8'h00;
            b2_ff <= 8'h00;
        end
        else if (take)
        begin
            b1_ff <= op_byte;
            b2_ff <= b1_ff;
        end
    end
    a_flip_carry: assert property (
        take && op_byte == `ASB_OP_FLIPC && fresh |=>
        flags_ff[`ASB_FL_C] != $past(flags_ff[`ASB_FL_C]) && $stable(acc_ff))
        else $error("carry flip wrong");
    a_force_carry: assert property (
        take && op_byte == `ASB_OP_FORCEC && fresh |=> flags_ff[`ASB_FL_C] && $stable(acc_ff))
        else $error("carry force wrong");
    a_invert_acc: assert property (
        take && op_byte == `ASB_OP_INVACC && fresh |=> acc_ff == ~$past(acc_ff))
        else $error("acc invert wrong");
    a_negate_acc: assert property (
        take && op_byte == `ASB_ED_NEG && b1_ff == `ASB_PFX_ED
        && !(b2_ff inside {8'hcb, 8'hed}) // a second ed is dropped, not a prefix
        |=> acc_ff == 8'h00 - $past(acc_ff) && flags_ff[`ASB_FL_N])
        else $error("acc negate wrong");
    a_bit_test_z: assert property (
        take && b1_ff == 8'hcb && !(b2_ff inside {8'hcb, 8'hed, 8'hdd, 8'hfd})
        && op_byte[7:6] == 2'b01 && op_byte[2:0] == 3'b111
        |=> flags_ff[`ASB_FL_Z] == !$past(acc_ff[op_byte[5:3]]) && $stable(acc_ff))
        else $error("bit test zero wrong");
    a_read_wait: assert property (
        mem_rd && !mem_rvalid |=> !op_ready)
        else $error("byte taken while read pending");
    a_answer_done: assert property (
        mem_rvalid && !op_ready && !mem_wr |=> done_ff)
        else $error("no done after read answer");
    a_write_after: assert property (
        mem_wr |-> done_ff && mem_addr_ff == $past(mem_addr_ff, 2))
        else $error("write out of place");
    c_rmw: cover property (mem_wr);
    c_slow: cover property (mem_rd ##1 !mem_rvalid [*2] ##1 mem_rvalid);
    c_bit: cover property (take && b1_ff == 8'hcb && op_byte[7:6] == 2'b01);
endmodule : asb_decode_chk
bind asb_decode asb_decode_chk i_asb_decode_chk (.clk(clk), .rst_n(rst_n),
    .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr_ff(mem_addr_ff), .mem_rvalid(mem_rvalid),
    .acc_ff(acc_ff), .flags_ff(flags_ff), .done_ff(done_ff));

// ===== verification/asb_mem_model.sv
// Purpose: memory partner for operand reads and writes
// Assumes: read data is address low byte xor a5
// Notes: data line toggles outside an answer so stale values never match
`timescale 1ns/1ps
module asb_mem_model (
    // bus from the decoder
    input wire logic clk,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr_ff,
    input wire logic [7:0] mem_wdata_ff,
    input wire logic [3:0] lat,
    // answer
    output logic mem_rvalid,
    output logic [7:0] mem_rdata,
    // capture for the bench
    output logic [15:0] rd_addr,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] wr_cnt
);
    int wait_cnt = 0;
    logic [7:0] val;
    initial
    begin
        mem_rvalid = 1'b0;
        mem_rdata = 8'h00;
        wr_cnt = 8'h00;
    end
    // answer lat cycles after the cycle that follows the strobe
    always @(negedge clk)
    begin
        mem_rvalid = 1'b0;
        mem_rdata = ~mem_rdata;
        if (wait_cnt == 1)
        begin
            mem_rvalid = 1'b1;
            mem_rdata = val;
        end
        if (wait_cnt > 0)
            wait_cnt--;
        if (mem_rd)
        begin
            wait_cnt = lat + 1;
            val = mem_addr_ff[7:0] ^ 8'ha5;
            rd_addr = mem_addr_ff;
        end
        if (mem_wr)
        begin
            wr_addr = mem_addr_ff;
            wr_data = mem_wdata_ff;
            wr_cnt++;
        end
    end
endmodule : asb_mem_model

// ===== verification/asb_decode_tb.sv
// Purpose: self checking bench of the decode block
// Assumes: registers start at all ones after reset
// Notes: expectations chained from reset values, tests run in order
`timescale 1ns/1ps
`include "asb_defines.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module asb_decode_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    logic [7:0] op_byte = 8'h00;
    logic [3:0] mem_lat = 4'h0;
    logic op_ready, mem_rd, mem_wr, mem_rvalid, done_ff;
    logic [15:0] mem_addr_ff, bc, de, hl, sp, ix, iy, rd_addr, wr_addr;
    logic [7:0] mem_wdata_ff, mem_rdata, acc_ff, flags_ff, wr_data, wr_cnt;
    int miscompares = 0;
    int tests_run = 0;
    asb_decode i_asb_decode (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
        .op_byte(op_byte), .op_ready(op_ready), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .acc_ff(acc_ff), .flags_ff(flags_ff),
        .byte_count_pair_ff(bc), .target_pair_ff(de), .memory_pointer_pair_ff(hl),
        .stack_pointer_ff(sp), .index_reg_x_ff(ix), .index_reg_y_ff(iy), .done_ff(done_ff));
    asb_mem_model i_asb_mem_model (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .lat(mem_lat),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .rd_addr(rd_addr),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_cnt(wr_cnt));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // bytes msb first; each held until taken, then wait for done and any write
    task automatic run(input logic [31:0] code, input int n);
        int k;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clk);
            op_valid = 1'b1;
            op_byte = code[i*8 +: 8];
            k = 0;
            while (op_ready !== 1'b1 && k < 50)
            begin
                @(negedge clk);
                k++;
            end
            if (k == 50)
            begin
                miscompares++;
                conclude();
            end
            @(posedge clk);
        end
        @(negedge clk);
        op_valid = 1'b0;
        k = 0;
        while (done_ff !== 1'b1 && k < 50)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 50)
        begin
            miscompares++;
            conclude();
        end
        repeat (2) @(negedge clk);
    endtask : run
    task automatic t_acc;
        run(32'hed44, 2);
        `CHK("neg acc", 8'h01, acc_ff)
        `CHK("neg sub flag", 1'b1, flags_ff[`ASB_FL_N])
        run(32'h27, 1);
        `CHK("adjust acc", 8'h9b, acc_ff)
        run(32'h2f, 1);
        `CHK("invert acc", 8'h64, acc_ff)
        run(32'h3f, 1);
        `CHK("flip carry", 1'b0, flags_ff[`ASB_FL_C])
        `CHK("flip acc", 8'h64, acc_ff)
        run(32'h37, 1);
        `CHK("force carry", 1'b1, flags_ff[`ASB_FL_C])
        $display("test acc done");
    endtask : t_acc
    task automatic t_pairs;
        run(32'h09, 1);
        `CHK("add hl", 16'hfffe, hl)
        run(32'hed42, 2);
        `CHK("sbc hl", 16'hfffe, hl)
        `CHK("sbc n", 1'b1, flags_ff[`ASB_FL_N])
        run(32'hed4a, 2);
        `CHK("adc hl", 16'hfffe, hl)
        `CHK("adc c", 2'b01, {flags_ff[`ASB_FL_N], flags_ff[`ASB_FL_C]})
        run(32'hed72, 2);
        `CHK("sbc sp", 16'hfffe, hl)
        `CHK("pair keep", 32'hffffffff, {de, sp})
        run(32'hdd09, 2);
        `CHK("add ix", 16'hfffe, ix)
        run(32'hfd29, 2);
        `CHK("add iy", 16'hfffe, iy)
        $display("test pairs done");
    endtask : t_pairs
    task automatic t_mem;
        logic [7:0] w0;
        w0 = wr_cnt;
        mem_lat = 4'h2;
        run(32'hddcb0546, 4);
        `CHK("ix addr", 16'h0003, rd_addr)
        `CHK("test z", 1'b1, flags_ff[`ASB_FL_Z])
        `CHK("test nowr", w0, wr_cnt)
        run(32'hfdcb014e, 4);
        `CHK("iy addr", 16'hffff, rd_addr)
        `CHK("test nz", 1'b0, flags_ff[`ASB_FL_Z])
        mem_lat = 4'h0;
        run(32'hed6f, 2);
        `CHK("rld mem", 24'hfffeb4, {wr_addr, wr_data})
        `CHK("rld acc", 8'h65, acc_ff)
        run(32'hed67, 2);
        `CHK("rrd mem", 8'h55, wr_data)
        `CHK("rrd acc", 8'h6b, acc_ff)
        $display("test mem done");
    endtask : t_mem
    task automatic t_shift;
        run(32'hcb20, 2);
        `CHK("sla b", 17'h1feff, {flags_ff[`ASB_FL_C], bc})
        run(32'hcb29, 2);
        `CHK("sra c", 16'hfeff, bc)
        run(32'hcb38, 2);
        `CHK("srl b", 17'h07fff, {flags_ff[`ASB_FL_C], bc})
        run(32'hcb16, 2);
        `CHK("rl mem", 8'hb6, wr_data)
        run(32'hcb1a, 2);
        `CHK("rr d", 17'h17fff, {flags_ff[`ASB_FL_C], de})
        run(32'hcb02, 2);
        `CHK("rlc d", 17'h0feff, {flags_ff[`ASB_FL_C], de})
        $display("test shift done");
    endtask : t_shift
    task automatic t_bits;
        run(32'hcb80, 2);
        `CHK("res b", 16'h7eff, bc)
        run(32'hcbff, 2);
        `CHK("set a", 8'heb, acc_ff)
        for (int b = 0; b < 8; b++)
        begin
            run({24'hcb, 2'b01, 3'(b), 3'b111}, 2);
            // 8'h14 is the inverse of the eb held in the accumulator
            `CHK("bit a", 1'(8'h14 >> b), flags_ff[`ASB_FL_Z])
            `CHK("bit keep", 8'heb, acc_ff)
        end
        run(32'hcb86, 2);
        `CHK("res mem", 24'hfffe5a, {wr_addr, wr_data})
        $display("test bits done");
    endtask : t_bits
    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        `CHK("reset acc", 8'hff, acc_ff)
        `CHK("reset hl", 16'hffff, hl)
        $display("test reset done");
        t_acc();
        t_pairs();
        t_mem();
        t_shift();
        t_bits();
        conclude();
    end
endmodule : asb_decode_tb
